//--- gdp_pkg.sv
package gdp_pkg;
  localparam int PHASES = 3;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CMD = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam int CTRL_RUN = 0;
  localparam int CTRL_HSSD = 1;
  localparam int CTRL_FEED = 2;
  localparam int CTRL_PULSE = 3;
  localparam int CMD_HS_LSB = 0;
  localparam int CMD_LS_LSB = 3;
  localparam int STAT_FAULT = 0;
  localparam int STAT_LIMIT = 1;
  localparam int STAT_STICKY = 2;
  localparam int STAT_LOCK = 3;
  localparam int STAT_RUN = 4;
  localparam int STAT_PULSE = 5;
  localparam int HTRANS_ACTIVE_BIT = 1;
  localparam logic [1:0] HRESP_OKAY = 2'h0;
  localparam int CLK_PERIOD_NS = 10;
  localparam int PULSE_NS = 6000;
  localparam int PULSE_CYCLES = (PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PULSE_W = 10;
  localparam int STOP_NS = 15000;
  localparam int STOP_CYCLES = STOP_NS / CLK_PERIOD_NS;
  localparam int RESTART_MS = 2000;
  localparam int RESTART_CYCLES = RESTART_MS * (1000000 / CLK_PERIOD_NS);
  localparam int RESTART_W = 28;
  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_LOCKOUT} gdp_state_t;
endpackage

//--- gdp_sync3.sv
`timescale 1ns/1ps
module gdp_sync3 #(
  parameter logic RESET_VAL = 1'b0
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic d,
  output logic q
);
  logic ff1_reg, ff2_reg, ff3_reg, q_reg;
  logic qNext;

  // Take a change only once the two settled stages agree
  always_comb begin
    qNext = (ff2_reg == ff3_reg) ? ff3_reg : q_reg;
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ff1_reg <= RESET_VAL;
      ff2_reg <= RESET_VAL;
      ff3_reg <= RESET_VAL;
      q_reg <= RESET_VAL;
    end else begin
      ff1_reg <= d;
      ff2_reg <= ff1_reg;
      ff3_reg <= ff2_reg;
      q_reg <= qNext;
    end
  end

  assign q = q_reg;
endmodule

//--- gdp_controller.sv
`timescale 1ns/1ps
module gdp_controller #(
  parameter int RESTART_CYCLES = gdp_pkg::RESTART_CYCLES
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic [1:0] hresp,
  output logic [gdp_pkg::PHASES-1:0] highSideCmd,
  output logic [gdp_pkg::PHASES-1:0] lowSideCmd,
  output logic highSideShutdown,
  input wire logic faultLineIn,
  output logic faultLineOut,
  output logic faultLineOe,
  input wire logic currentLimitFlag
);
  logic faultHigh, limitSync, faultLow;
  logic hreadyout_reg, hreadyout_next;
  logic [31:0] hrdata_reg, hrdata_next;
  logic wrPend_reg, wrPend_next, rdPend_reg, rdPend_next;
  logic [7:0] addr_reg, addr_next;
  logic run_reg, run_next, hssd_reg, hssd_next, feed_reg, feed_next;
  logic [gdp_pkg::PHASES-1:0] hsSet_reg, hsSet_next, lsSet_reg, lsSet_next;
  logic sticky_reg, sticky_next;
  logic pulseStart;
  gdp_pkg::gdp_state_t state_reg, state_next;
  logic [gdp_pkg::RESTART_W-1:0] lockCnt_reg, lockCnt_next;
  logic [gdp_pkg::PULSE_W-1:0] pulseCnt_reg, pulseCnt_next;
  logic [gdp_pkg::PHASES-1:0] hsOut_reg, hsOut_next, lsOut_reg, lsOut_next;
  logic hsd_reg, hsd_next, oe_reg, oe_next;

  gdp_sync3 #(.RESET_VAL(1'b1)) faultSyncU (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .d(faultLineIn),
    .q(faultHigh)
  );

  gdp_sync3 #(.RESET_VAL(1'b0)) limitSyncU (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .d(currentLimitFlag),
    .q(limitSync)
  );

  assign faultLow = ~faultHigh;

  // Reads take one wait state so a read right after a write sees the new value
  always_comb begin
    hreadyout_next = 1'b1;
    hrdata_next = hrdata_reg;
    wrPend_next = 1'b0;
    rdPend_next = 1'b0;
    addr_next = addr_reg;
    run_next = run_reg;
    hssd_next = hssd_reg;
    feed_next = feed_reg;
    hsSet_next = hsSet_reg;
    lsSet_next = lsSet_reg;
    sticky_next = sticky_reg;
    pulseStart = 1'b0;
    if (hsel && htrans[gdp_pkg::HTRANS_ACTIVE_BIT] && hready) begin
      addr_next = {haddr[7:2], 2'h0};
      wrPend_next = hwrite;
      rdPend_next = ~hwrite;
      hreadyout_next = hwrite;
    end
    if (rdPend_reg) begin
      hrdata_next = 32'h0;
      unique case (addr_reg)
        gdp_pkg::ADDR_CTRL: begin
          hrdata_next[gdp_pkg::CTRL_RUN] = run_reg;
          hrdata_next[gdp_pkg::CTRL_HSSD] = hssd_reg;
          hrdata_next[gdp_pkg::CTRL_FEED] = feed_reg;
        end
        gdp_pkg::ADDR_CMD: begin
          hrdata_next[gdp_pkg::CMD_HS_LSB +: gdp_pkg::PHASES] = hsSet_reg;
          hrdata_next[gdp_pkg::CMD_LS_LSB +: gdp_pkg::PHASES] = lsSet_reg;
        end
        gdp_pkg::ADDR_STATUS: begin
          hrdata_next[gdp_pkg::STAT_FAULT] = faultLow;
          hrdata_next[gdp_pkg::STAT_LIMIT] = limitSync;
          hrdata_next[gdp_pkg::STAT_STICKY] = sticky_reg;
          hrdata_next[gdp_pkg::STAT_LOCK] = (state_reg == gdp_pkg::ST_LOCKOUT);
          hrdata_next[gdp_pkg::STAT_RUN] = (state_reg == gdp_pkg::ST_RUN);
          hrdata_next[gdp_pkg::STAT_PULSE] = oe_reg;
        end
        default: hrdata_next = 32'h0;
      endcase
    end
    if (wrPend_reg) begin
      unique case (addr_reg)
        gdp_pkg::ADDR_CTRL: begin
          run_next = hwdata[gdp_pkg::CTRL_RUN];
          hssd_next = hwdata[gdp_pkg::CTRL_HSSD];
          feed_next = hwdata[gdp_pkg::CTRL_FEED];
          pulseStart = hwdata[gdp_pkg::CTRL_PULSE];
        end
        gdp_pkg::ADDR_CMD: begin
          hsSet_next = hwdata[gdp_pkg::CMD_HS_LSB +: gdp_pkg::PHASES];
          lsSet_next = hwdata[gdp_pkg::CMD_LS_LSB +: gdp_pkg::PHASES];
        end
        gdp_pkg::ADDR_STATUS: begin
          if (hwdata[gdp_pkg::STAT_STICKY]) begin
            sticky_next = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
    // A fault in the clearing cycle still sets the sticky bit
    if (faultLow) begin
      sticky_next = 1'b1;
    end
    // Restart needs a fresh run request
    if (state_reg == gdp_pkg::ST_LOCKOUT) begin
      run_next = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      hreadyout_reg <= 1'b1;
      hrdata_reg <= 32'h0;
      wrPend_reg <= 1'b0;
      rdPend_reg <= 1'b0;
      addr_reg <= 8'h0;
      run_reg <= 1'b0;
      hssd_reg <= 1'b0;
      feed_reg <= 1'b0;
      hsSet_reg <= '0;
      lsSet_reg <= '0;
      sticky_reg <= 1'b0;
    end else begin
      hreadyout_reg <= hreadyout_next;
      hrdata_reg <= hrdata_next;
      wrPend_reg <= wrPend_next;
      rdPend_reg <= rdPend_next;
      addr_reg <= addr_next;
      run_reg <= run_next;
      hssd_reg <= hssd_next;
      feed_reg <= feed_next;
      hsSet_reg <= hsSet_next;
      lsSet_reg <= lsSet_next;
      sticky_reg <= sticky_next;
    end
  end

  always_comb begin
    state_next = state_reg;
    lockCnt_next = lockCnt_reg;
    pulseCnt_next = pulseCnt_reg;
    unique case (state_reg)
      gdp_pkg::ST_IDLE: begin
        if (run_reg && !faultLow) begin
          state_next = gdp_pkg::ST_RUN;
        end
      end
      gdp_pkg::ST_RUN: begin
        // Stop at once on a low fault line
        if (faultLow) begin
          state_next = gdp_pkg::ST_LOCKOUT;
          lockCnt_next = '0;
        end else if (!run_reg) begin
          state_next = gdp_pkg::ST_IDLE;
        end
      end
      gdp_pkg::ST_LOCKOUT: begin
        // Restart wait counted from line release
        if (faultLow) begin
          lockCnt_next = '0;
        end else if (lockCnt_reg == gdp_pkg::RESTART_W'(RESTART_CYCLES - 1)) begin
          state_next = gdp_pkg::ST_IDLE;
        end else begin
          lockCnt_next = lockCnt_reg + 1'b1;
        end
      end
      // Spare code of the state word falls back to idle
      default: begin
        state_next = gdp_pkg::ST_IDLE;
      end
    endcase
    // Own shutdown pulse held at least six microseconds
    if (pulseCnt_reg != '0) begin
      pulseCnt_next = pulseCnt_reg - 1'b1;
    end else if (pulseStart) begin
      pulseCnt_next = gdp_pkg::PULSE_W'(gdp_pkg::PULSE_CYCLES);
    end
    // Commands fall with the state change, far inside the limit
    hsOut_next = (state_next == gdp_pkg::ST_RUN) ? hsSet_reg : '0;
    lsOut_next = (state_next == gdp_pkg::ST_RUN) ? lsSet_reg : '0;
    // Inverted fault feeds the shutdown input when enabled
    hsd_next = hssd_reg | (feed_reg & faultLow);
    oe_next = (pulseCnt_next != '0);
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= gdp_pkg::ST_IDLE;
      lockCnt_reg <= '0;
      pulseCnt_reg <= '0;
      hsOut_reg <= '0;
      lsOut_reg <= '0;
      hsd_reg <= 1'b0;
      oe_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      lockCnt_reg <= lockCnt_next;
      pulseCnt_reg <= pulseCnt_next;
      hsOut_reg <= hsOut_next;
      lsOut_reg <= lsOut_next;
      hsd_reg <= hsd_next;
      oe_reg <= oe_next;
    end
  end

  assign hreadyout = hreadyout_reg;
  assign hrdata = hrdata_reg;
  assign hresp = gdp_pkg::HRESP_OKAY;
  assign highSideCmd = hsOut_reg;
  assign lowSideCmd = lsOut_reg;
  assign highSideShutdown = hsd_reg;
  assign faultLineOut = 1'b0;
  assign faultLineOe = oe_reg;

  localparam int PULSE_MIN = gdp_pkg::PULSE_CYCLES;
  logic [gdp_pkg::PULSE_W-1:0] oeLen;
  logic [gdp_pkg::RESTART_W-1:0] sinceFault;
  logic seenFault;
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      oeLen <= '0;
      sinceFault <= '0;
      seenFault <= 1'b0;
    end else begin
      oeLen <= oe_reg ? oeLen + 1'b1 : '0;
      if (faultLow) begin
        sinceFault <= '0;
        seenFault <= 1'b1;
      end else if (sinceFault != '1) begin
        sinceFault <= sinceFault + 1'b1;
      end
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  sequence lineLowSeen;
    !faultLineIn [*4];
  endsequence
  sequence cmdsClear;
    (highSideCmd == '0) && (lowSideCmd == '0);
  endsequence

  cmd_removal_a: assert property (lineLowSeen |-> ##[0:6] cmdsClear)
    else $error("commands not removed after fault");
  motor_stop_a: assert property ((state_reg == gdp_pkg::ST_RUN) && faultLow
    |=> ((state_reg == gdp_pkg::ST_LOCKOUT) and cmdsClear))
    else $error("motor not stopped on fault");
  restart_wait_a: assert property ($rose(state_reg == gdp_pkg::ST_RUN) && seenFault
    |-> sinceFault >= gdp_pkg::RESTART_W'(RESTART_CYCLES))
    else $error("restart before wait elapsed");
  fault_feed_a: assert property (feed_reg && faultLow |=> highSideShutdown)
    else $error("fault not fed to shutdown");
  pulse_width_a: assert property ($fell(faultLineOe) |-> $past(oeLen) >= PULSE_MIN - 1)
    else $error("shutdown pulse too short");
  pulse_level_a: assert property (faultLineOe |-> !faultLineOut)
    else $error("fault line driven high");
endmodule

//--- gdp_device_model.sv
`timescale 1ns/1ps
module gdp_device_model #(
  parameter int HOLD = 100,
  parameter int BLANK = 20
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [2:0] highSideCmd,
  input wire logic [2:0] lowSideCmd,
  input wire logic highSideShutdown,
  input wire logic faultLine,
  input wire logic tripReq,
  input wire logic limitReq,
  output logic faultPull,
  output logic currentLimitFlag,
  output logic [2:0] highGateDrive,
  output logic [2:0] lowGateDrive
);
  int holdCnt;
  int blankCnt;
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      holdCnt <= 0;
      blankCnt <= 0;
    end else begin
      holdCnt <= tripReq ? HOLD : (holdCnt != 0 ? holdCnt - 1 : 0);
      blankCnt <= !limitReq ? 0 : (blankCnt < BLANK ? blankCnt + 1 : blankCnt);
    end
  end
  // Only a trip pulls the line
  assign faultPull = holdCnt != 0;
  assign currentLimitFlag = (blankCnt == BLANK) | faultPull;
  assign highGateDrive = highSideShutdown ? 3'h0 : highSideCmd;
  // Low sides follow only while line high
  assign lowGateDrive = faultLine ? lowSideCmd : 3'h0;
endmodule

//--- testbench.sv
`timescale 1ns/1ps
module testbench;
  logic sys_clk, sys_rst, hsel, hwrite, tripReq, limitReq;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans, hresp;
  logic [2:0] hsize, hsc, lsc, hg, lg;
  logic hss, foOut, foOe, clf, pull;
  wire hready;
  wire faultLine = ~(foOe | pull);
  integer failures = 0, check_count = 0, seed = 80044, cyc = 0, n;
  gdp_controller #(.RESTART_CYCLES(50)) gdp_controller_inst (.sys_clk(sys_clk),
    .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hready),
    .hrdata(hrdata), .hresp(hresp), .highSideCmd(hsc), .lowSideCmd(lsc),
    .highSideShutdown(hss), .faultLineIn(faultLine), .faultLineOut(foOut),
    .faultLineOe(foOe), .currentLimitFlag(clf));
  gdp_device_model gdp_device_model_inst (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .highSideCmd(hsc), .lowSideCmd(lsc), .highSideShutdown(hss),
    .faultLine(faultLine), .tripReq(tripReq), .limitReq(limitReq),
    .faultPull(pull), .currentLimitFlag(clf), .highGateDrive(hg), .lowGateDrive(lg));
  initial begin
    sys_clk = 0;
    forever #5 sys_clk = ~sys_clk;
  end
  task conclude;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Generous ceiling: the whole sequence needs about a thousand cycles
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      conclude();
    end
  end
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Values read right after the edge are the pre-edge, sampled ones
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge sys_clk);
    hsel <= 1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge sys_clk); while (hready !== 1'b1);
    hsel <= 0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge sys_clk); while (hready !== 1'b1);
    r = hrdata;
  endtask
  task waitc(input int k);
    repeat (k) @(posedge sys_clk);
  endtask
  initial begin
    hsel = 0;
    haddr = 0;
    htrans = 0;
    hwrite = 0;
    hsize = 3'h2;
    hwdata = 0;
    tripReq = 0;
    limitReq = 0;
    sys_rst = 1;
    waitc(2);
    sys_rst <= 0;
    bus(0, gdp_pkg::ADDR_STATUS, 0, rd);
    chk("status", 32'h0, rd);
    bus(0, 8'h3c, 0, rd);
    chk("unmapped", 32'h0, rd);
    bus(1, gdp_pkg::ADDR_CTRL, 32'h1, rd);
    repeat (4) begin
      n = $random(seed) & 63;
      bus(1, gdp_pkg::ADDR_CMD, n, rd);
      waitc(3);
      chk("highGate", n[2:0], hg);
      chk("lowGate", n[5:3], lg);
    end
    // Trip while running: line falls, motor must stop
    @(posedge sys_clk) tripReq <= 1;
    @(posedge sys_clk) tripReq <= 0;
    waitc(10);
    chk("lowGate", 32'h0, lg);
    chk("highCmd", 32'h0, hsc);
    bus(1, gdp_pkg::ADDR_CTRL, 32'h1, rd);
    bus(0, gdp_pkg::ADDR_STATUS, 0, rd);
    chk("tripStatus", 32'h0f, rd);
    waitc(200);
    bus(1, gdp_pkg::ADDR_STATUS, 32'h4, rd);
    bus(1, gdp_pkg::ADDR_CTRL, 32'h1, rd);
    bus(0, gdp_pkg::ADDR_STATUS, 0, rd);
    chk("restart", 32'h10, rd);
    @(posedge sys_clk) limitReq <= 1;
    waitc(30);
    chk("lowGate", {29'h0, lsc}, lg);
    bus(0, gdp_pkg::ADDR_STATUS, 0, rd);
    chk("limitOn", 32'h12, rd);
    @(posedge sys_clk) limitReq <= 0;
    waitc(5);
    bus(0, gdp_pkg::ADDR_STATUS, 0, rd);
    chk("limitOff", 32'h10, rd);
    bus(1, gdp_pkg::ADDR_CTRL, 32'h3, rd);
    waitc(3);
    chk("shutdown", 32'h1, hss);
    chk("highGate", 32'h0, hg);
    // Own pulse with the line fed back into shutdown
    bus(1, gdp_pkg::ADDR_CTRL, 32'hd, rd);
    n = 0;
    while (foOe !== 1'b1 && n < 20) begin
      @(posedge sys_clk);
      n++;
    end
    n = 0;
    while (foOe === 1'b1 && n < 2000) begin
      if (n == 20) chk("feed", 32'h1, hss);
      if (n == 20) chk("lowGate", 32'h0, lg);
      @(posedge sys_clk);
      n++;
    end
    chk("pulseLen", gdp_pkg::PULSE_CYCLES, n);
    conclude();
  end
endmodule
